// file: scp_params.svh
// Constants for the system clock select and prescaler block.
// Assumes a single 200 MHz clock and a classic Wishbone slave port.
//
// What the document asks of this block and its software
// RL1 - Fuse code 0000 selects external clock pin
// RL2 - External clock: 6 CK wake, 14CK plus delay
// RL3 - Source changes under 2 percent per cycle
// RL4 - Timer oscillator only with internal RC clock
// RL5 - Timer external-clock bit accepts pin clock
// RL6 - Clock output fuse drives clock on pin
// RL7 - Clock output pin carries the divided clock; the code toggles the pin on each divided tick, so it runs at half that rate
// RL8 - Divided clock feeds I/O, ADC, CPU, flash
// RL9 - Divider changes without glitches or overshoot
// RL10 - New rate active within T1+T2 to T1+2T2
// RL11 - Software: enable write, then value within four
// RL12 - Software keeps interrupts off during change
// RL13 - Change enable sets only with others zero
// RL14 - Enable clears after four cycles or write
// RL15 - Select code gives factor two to code
// RL16 - Reset select 0000, or 0011 with fuse
// RL17 - Any select value accepted regardless of fuse
// RL18 - Factory trim loaded at every reset
// RL19 - Trim bit 7 picks the frequency range
// RL20 - Trim bits 6:0 tune within range
// RL21 - Software avoids trim above 8.8 MHz writes
// RL22 - Divider control bits 6:4 read zero
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// Clock and timing
`define SCP_CLK_PERIOD_NS   5
`define SCP_T_4MS_NS        4100000
`define SCP_T_65MS_NS       65000000
`define SCP_RESET_CK        4'he
`define SCP_WAKE_CK         4'h6
`define SCP_PCE_CYCLES      3'h4

// Fuse codes
`define SCP_CLOCK_SOURCE_FUSES_EXT       4'h0
`define SCP_CLOCK_SOURCE_FUSES_RC        4'h2
`define SCP_SUT_4MS         2'h1
`define SCP_SUT_65MS        2'h2

// Register byte offsets
`define SCP_OFS_TRIM        4'h0
`define SCP_OFS_DIVCTL      4'h4
`define SCP_OFS_TIMER       4'h8
`define SCP_OFS_STATUS      4'hc

// Field positions
`define SCP_DIVCTL_PCE      7
`define SCP_TIMER_TIMER_EXTERNAL_CLOCK_SELECT    0

// Reset values and upper limit of the divider select
`define SCP_DIVSEL_RST      4'h0
`define SCP_DIVSEL_RST_DIV8 4'h3
`define SCP_DIVSEL_MAX      4'h8

`endif

// file: scp_pkg.sv
// Types and shared arithmetic for the clock select and prescaler.
// Assumes scp_params.svh is available on the include path.
`default_nettype none
`include "scp_params.svh"

package scp_pkg;

   // Start-up sequencer, Gray coded along count, delay, run, wake
   typedef enum logic [1:0] {
      SCP_ST_COUNT = 2'b00,
      SCP_ST_DELAY = 2'b01,
      SCP_ST_RUN   = 2'b11,
      SCP_ST_WAKE  = 2'b10
   } scp_state_e;

   typedef logic [3:0] scp_divsel_t;
   typedef logic [7:0] scp_count_t;

   // Terminal count of the divider; reserved codes clamp to code 8, count 255
   function automatic scp_count_t scp_terminal(input scp_divsel_t sel);
      scp_divsel_t s;
      s = (sel > `SCP_DIVSEL_MAX) ? `SCP_DIVSEL_MAX : sel;
      scp_terminal = 8'((9'h001 << s) - 9'h001);
   endfunction

endpackage

`default_nettype wire

// file: scp_divider.sv
// Glitch-free divider of the source clock ticks.
// Assumes src_tick_i is one cycle per source clock edge, same clock.
`timescale 1ns/10ps
`default_nettype none

module scp_divider (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Source tick and new divider select
   input  wire logic                 src_tick_i,
   input  wire scp_pkg::scp_divsel_t sel_i,
   input  wire logic                 load_i,
   // Divided tick
   output logic                      div_tick_o
);
   import scp_pkg::*;

   scp_divsel_t cur_sel_r;   // Select in force
   scp_divsel_t pend_sel_r;  // Select waiting for a period boundary
   logic        pend_r;      // A new select is waiting
   scp_count_t  cnt_r;       // Source ticks in this period

   wire logic at_end;        // Last source tick of the period
   assign at_end = src_tick_i && (cnt_r == scp_terminal(cur_sel_r));

   // New value waits for the end of the current period so that no
   // period is shortened; the next period has the new length unless the load fell in the last cycle of the current one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_r     <= 1'b0;
         pend_sel_r <= '0;
      end else if (load_i) begin
         pend_r     <= 1'b1;
         pend_sel_r <= sel_i;
      end else if (at_end) begin
         pend_r     <= 1'b0; // RL9
      end
   end

   // Period counter and select switch at the boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r     <= '0;
         cur_sel_r <= '0;
      end else if (at_end) begin
         cnt_r <= '0;
         if (pend_r) begin
            cur_sel_r <= pend_sel_r; // RL10
         end
      end else if (src_tick_i) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // One pulse per divided clock period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_tick_o <= 1'b0;
      end else begin
         div_tick_o <= at_end; // RL15
      end
   end

endmodule

`default_nettype wire

// file: scp_clock_ctrl.sv
// Top of the clock select, start-up and prescaler block.
// Assumes one 200 MHz clock, a classic Wishbone master on the
// register port and fuse levels that are stable while running.
`timescale 1ns/10ps
`default_nettype none
`include "scp_params.svh"

module scp_clock_ctrl #(
   parameter int DLY_4MS_CYC  = `SCP_T_4MS_NS / `SCP_CLK_PERIOD_NS,
   parameter int DLY_65MS_CYC = `SCP_T_65MS_NS / `SCP_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Fuses
   input  wire logic [3:0]  clock_source_fuses_i,
   input  wire logic [1:0]  startup_delay_fuses_i,
   input  wire logic        clock_output_fuse_i,
   input  wire logic        divide_by_eight_fuse_i,
   input  wire logic [7:0]  factory_trim_i,
   // Power management
   input  wire logic        wake_i,
   // Pins
   input  wire logic        main_osc_input_pin_i,
   input  wire logic        timer_osc_input_pin_i,
   input  wire logic        gpio_out_i,
   input  wire logic        gpio_oe_n_i,
   output logic             clock_output_pin_o,
   output logic             clock_output_pin_oe_n_o,
   // Clock domain enables
   output logic             clk_io_en_o,
   output logic             clk_adc_en_o,
   output logic             clk_cpu_en_o,
   output logic             clk_flash_en_o,
   // Core control
   output logic             core_reset_o,
   output logic             core_run_o,
   // Timer oscillator
   output logic             timer_osc_enable_o,
   output logic             timer_tick_o,
   // Oscillator trim
   output logic             trim_range_bit_o,
   output logic [6:0]       rc_trim_tune_o
);
   import scp_pkg::*;

   localparam logic [23:0] DLY4  = 24'(DLY_4MS_CYC);  // Short delay
   localparam logic [23:0] DLY65 = 24'(DLY_65MS_CYC); // Long delay

   // Pin synchronisers and edge history
   logic [1:0]  main_sync_r;   // External clock pin sync
   logic        main_prev_r;   // Previous synced level
   logic [1:0]  tosc_sync_r;   // Timer pin sync
   logic        tosc_prev_r;   // Previous synced level

   // Registers seen by software
   logic [7:0]  rc_trim_r;     // Oscillator trim
   scp_divsel_t divsel_r;      // Divider select
   logic        pce_r;         // Change enable
   logic [2:0]  pce_cnt_r;     // Cycles left in change window
   logic        tmr_ext_r;     // Timer external clock select

   // Control state
   logic        init_done_r;   // Straps captured after reset
   scp_state_e  state_r;       // Start-up sequencer
   scp_state_e  state_nxt;     // Next sequencer state
   logic [3:0]  ck_cnt_r;      // Source ticks counted
   logic [23:0] dly_cnt_r;     // Delay cycles counted
   logic [23:0] dly_tgt_r;     // Delay length for this start
   logic        clkout_tog_r;  // Divided clock waveform
   logic        div_load_r;    // Pulse to divider on new select

   wire logic   div_tick;      // Divided tick from the divider

   // Source select and ticks
   wire logic ext_sel;         // External clock chosen
   wire logic src_tick;        // One cycle per source clock
   wire logic timer_allowed;   // Timer oscillator usable
   wire logic timer_edge;      // Rising edge on timer pin
   assign ext_sel       = (clock_source_fuses_i == `SCP_CLOCK_SOURCE_FUSES_EXT); // RL1
   assign src_tick      = ext_sel ? (main_sync_r[1] && !main_prev_r) : 1'b1;
   assign timer_allowed = (clock_source_fuses_i == `SCP_CLOCK_SOURCE_FUSES_RC);  // RL4
   assign timer_edge    = tosc_sync_r[1] && !tosc_prev_r;

   // Bus decode
   wire logic bus_req;         // Request in progress
   wire logic wr_en;           // Write takes effect now
   wire logic hit_trim;        // Trim register addressed
   wire logic hit_div;         // Divider control addressed
   wire logic hit_tmr;         // Timer control addressed
   wire logic hit_stat;        // Status register addressed
   assign bus_req  = wb_cyc_i && wb_stb_i;
   assign wr_en    = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign hit_trim = (wb_adr_i == `SCP_OFS_TRIM);
   assign hit_div  = (wb_adr_i == `SCP_OFS_DIVCTL);
   assign hit_tmr  = (wb_adr_i == `SCP_OFS_TIMER);
   assign hit_stat = (wb_adr_i == `SCP_OFS_STATUS);

   // Divider control write classes
   wire logic div_wr;          // Write to divider control
   wire logic pce_arm;         // Enable bit alone, others zero
   wire logic sel_write;       // Select write inside window
   assign div_wr    = wr_en && hit_div;
   assign pce_arm   = div_wr && wb_dat_i[`SCP_DIVCTL_PCE] // RL13
                      && (wb_dat_i[6:0] == 7'h00);
   assign sel_write = div_wr && pce_r && !wb_dat_i[`SCP_DIVCTL_PCE];

   // Read data mux; unmapped offsets read zero
   wire logic [31:0] rd_data;
   assign rd_data = hit_trim ? {24'h000000, rc_trim_r} :
                    hit_div  ? {24'h000000, pce_r, 3'h0, divsel_r} : // RL22
                    hit_tmr  ? {31'h00000000, tmr_ext_r} :
                    hit_stat ? {26'h0000000, core_run_o, core_reset_o,
                                timer_allowed, ext_sel, state_r} :
                    32'h00000000;

   // Two-flop synchronisers on both clock pins; reset high so that a
   // pin resting high gives no false edge after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_sync_r <= 2'h3;
         main_prev_r <= 1'b1;
         tosc_sync_r <= 2'h3;
         tosc_prev_r <= 1'b1;
      end else begin
         main_sync_r <= {main_sync_r[0], main_osc_input_pin_i};
         main_prev_r <= main_sync_r[1];
         tosc_sync_r <= {tosc_sync_r[0], timer_osc_input_pin_i};
         tosc_prev_r <= tosc_sync_r[1];
      end
   end

   // Wishbone answer one cycle after the request, dropped after one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // Straps and factory trim captured in the first cycle after reset,
   // since a synchronous reset value should stay a constant
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_done_r <= 1'b0;
      end else begin
         init_done_r <= 1'b1;
      end
   end

   // Trim register: factory value at reset, software may overwrite
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_trim_r <= 8'h00;
      end else if (!init_done_r) begin
         rc_trim_r <= factory_trim_i; // RL18
      end else if (wr_en && hit_trim) begin
         rc_trim_r <= wb_dat_i[7:0];
      end
   end

   // Trim outputs split into range and tune fields
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_range_bit_o <= 1'b0;
         rc_trim_tune_o   <= 7'h00;
      end else begin
         trim_range_bit_o <= rc_trim_r[7];   // RL19
         rc_trim_tune_o   <= rc_trim_r[6:0]; // RL20
      end
   end

   // Change enable window: a second arm write neither extends nor
   // clears it; a select write or the timeout closes it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pce_r     <= 1'b0;
         pce_cnt_r <= 3'h0;
      end else if (pce_r) begin
         if (sel_write || pce_cnt_r == 3'h1) begin
            pce_r     <= 1'b0; // RL14
            pce_cnt_r <= 3'h0;
         end else begin
            pce_cnt_r <= pce_cnt_r - 3'h1;
         end
      end else if (pce_arm) begin
         pce_r     <= 1'b1;
         pce_cnt_r <= `SCP_PCE_CYCLES;
      end
   end

   // Divider select: fuse sets the start value, any code accepted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divsel_r   <= `SCP_DIVSEL_RST;
         div_load_r <= 1'b0;
      end else if (!init_done_r) begin
         divsel_r   <= divide_by_eight_fuse_i ? `SCP_DIVSEL_RST_DIV8 // RL16
                                              : `SCP_DIVSEL_RST;
         div_load_r <= 1'b1;
      end else if (sel_write) begin
         divsel_r   <= wb_dat_i[3:0]; // RL17
         div_load_r <= 1'b1;
      end else begin
         div_load_r <= 1'b0;
      end
   end

   // Glitch-free divider of the source ticks
   scp_divider u_div (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .src_tick_i (src_tick),
      .sel_i      (divsel_r),
      .load_i     (div_load_r),
      .div_tick_o (div_tick)
   );

   // Timer pin: register bit picks external clock over crystal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmr_ext_r <= 1'b0;
      end else if (wr_en && hit_tmr) begin
         tmr_ext_r <= wb_dat_i[`SCP_TIMER_TIMER_EXTERNAL_CLOCK_SELECT]; // RL5
      end
   end

   // Timer oscillator enable and tick, only on the RC clock; the
   // synchroniser needs the system clock well above the pin rate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_osc_enable_o <= 1'b0;
         timer_tick_o       <= 1'b0;
      end else begin
         timer_osc_enable_o <= timer_allowed && !tmr_ext_r; // RL4
         timer_tick_o       <= timer_allowed && timer_edge; // RL5
      end
   end

   // Start-up sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SCP_ST_COUNT: begin
            // 14 source cycles, then the fuse-chosen delay
            if (src_tick && ck_cnt_r == `SCP_RESET_CK - 4'h1) begin
               if (startup_delay_fuses_i == `SCP_SUT_4MS ||
                   startup_delay_fuses_i == `SCP_SUT_65MS) begin
                  state_nxt = SCP_ST_DELAY; // RL2
               end else begin
                  state_nxt = SCP_ST_RUN;
               end
            end
         end
         SCP_ST_DELAY: begin
            if (dly_cnt_r == dly_tgt_r - 24'h000001) begin
               state_nxt = SCP_ST_RUN;
            end
         end
         SCP_ST_RUN: begin
            if (wake_i) begin
               state_nxt = SCP_ST_WAKE;
            end
         end
         SCP_ST_WAKE: begin
            // Six source cycles after leaving a deep sleep
            if (src_tick && ck_cnt_r == `SCP_WAKE_CK - 4'h1) begin
               state_nxt = SCP_ST_RUN; // RL2
            end
         end
         default: begin
            state_nxt = SCP_ST_COUNT;
         end
      endcase
   end

   // Sequencer state and its counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= SCP_ST_COUNT;
         ck_cnt_r  <= 4'h0;
         dly_cnt_r <= 24'h000000;
         dly_tgt_r <= DLY4;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            ck_cnt_r  <= 4'h0;
            dly_cnt_r <= 24'h000000;
         end else if (state_r == SCP_ST_DELAY) begin
            dly_cnt_r <= dly_cnt_r + 24'h000001;
         end else if (src_tick) begin
            ck_cnt_r <= ck_cnt_r + 4'h1;
         end
         if (state_r == SCP_ST_COUNT) begin
            dly_tgt_r <= (startup_delay_fuses_i == `SCP_SUT_65MS) ? DLY65 : DLY4;
         end
      end
   end

   // Core held in reset until the start-up delay has run out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_reset_o <= 1'b1;
         core_run_o   <= 1'b0;
      end else begin
         core_reset_o <= (state_nxt == SCP_ST_COUNT) || (state_nxt == SCP_ST_DELAY);
         core_run_o   <= (state_nxt == SCP_ST_RUN);
      end
   end

   // Divided clock to the synchronous domains, also while the
   // core is held, as peripherals need clocks to reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_io_en_o    <= 1'b0;
         clk_adc_en_o   <= 1'b0;
         clk_cpu_en_o   <= 1'b0;
         clk_flash_en_o <= 1'b0;
      end else begin
         clk_io_en_o    <= div_tick; // RL8
         clk_adc_en_o   <= div_tick;
         clk_cpu_en_o   <= div_tick;
         clk_flash_en_o <= div_tick;
      end
   end

   // Clock output waveform toggles on each divided tick; a flop can
   // only show half the tick rate, a limit of the one-clock design
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clkout_tog_r <= 1'b0;
      end else if (div_tick) begin
         clkout_tog_r <= !clkout_tog_r; // RL7
      end
   end

   // Pin mux: fuse overrides normal I/O, during core reset too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_output_pin_o      <= 1'b0;
         clock_output_pin_oe_n_o <= 1'b1;
      end else if (clock_output_fuse_i) begin
         clock_output_pin_o      <= clkout_tog_r; // RL6
         clock_output_pin_oe_n_o <= 1'b0;
      end else begin
         clock_output_pin_o      <= gpio_out_i;
         clock_output_pin_oe_n_o <= gpio_oe_n_i;
      end
   end

endmodule

`default_nettype wire

// file: scp_ext_clk_src.sv
// Far-side model: board clock on the main and timer oscillator pins.
// Assumes the bench gates the main clock with run_i; timer clock is free.
`timescale 1ns/10ps
`default_nettype none

module scp_ext_clk_src #(
   parameter int MAIN_HALF_NS = 23,
   parameter int TMR_HALF_NS  = 97
) (
   // Control
   input  wire logic run_i,
   // Pins
   output logic      main_pin_o,
   output logic      timer_pin_o
);
   // Both pins start low
   initial begin
      main_pin_o = 1'b0;
      timer_pin_o = 1'b0;
   end

   // Fixed half period, so no drift between cycles; stands still when off
   always begin
      #(MAIN_HALF_NS);
      if (run_i) begin
         main_pin_o = ~main_pin_o;
      end
   end

   // Timer clock well below a quarter of the system clock
   always begin
      #(TMR_HALF_NS);
      timer_pin_o = ~timer_pin_o;
   end
endmodule

`default_nettype wire

// file: scp_clock_ctrl_checker.sv
// Port-level checks of the clock control block.
// Assumes binding to scp_clock_ctrl, one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
`include "scp_params.svh"

module scp_clock_ctrl_checker (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Bus
   input wire logic [3:0]  wb_adr_i,
   input wire logic        wb_we_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Fuses and pin
   input wire logic [3:0]  clock_source_fuses_i,
   input wire logic        clock_output_fuse_i,
   input wire logic        gpio_oe_n_i,
   input wire logic        clock_output_pin_oe_n_o,
   // Enables and core control
   input wire logic        clk_io_en_o,
   input wire logic        clk_adc_en_o,
   input wire logic        clk_cpu_en_o,
   input wire logic        clk_flash_en_o,
   input wire logic        core_reset_o,
   input wire logic        core_run_o,
   input wire logic        timer_osc_enable_o,
   input wire logic        timer_tick_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_oe_fuse: assert property (clock_output_fuse_i |=> !clock_output_pin_oe_n_o)
      else $error("clock pin not driven");
   a_oe_gpio: assert property (!clock_output_fuse_i |=>
      clock_output_pin_oe_n_o == $past(gpio_oe_n_i))
      else $error("pin enable not from io");
   a_dom_same: assert property (clk_adc_en_o == clk_io_en_o && clk_cpu_en_o == clk_io_en_o
      && clk_flash_en_o == clk_io_en_o)
      else $error("domain enables differ");
   a_run_excl: assert property (core_run_o |-> !core_reset_o)
      else $error("run during reset");
   a_boot_run: assert property ($fell(core_reset_o) |-> ##[0:1] core_run_o)
      else $error("run late after start-up");
   a_wake_len: assert property ($fell(core_run_o) && clock_source_fuses_i != `SCP_CLOCK_SOURCE_FUSES_EXT
      |-> !core_run_o [*5] ##[1:3] core_run_o)
      else $error("wake length wrong");
   a_timer_rc: assert property (timer_tick_o || timer_osc_enable_o
      |-> clock_source_fuses_i == `SCP_CLOCK_SOURCE_FUSES_RC)
      else $error("timer active off RC");
   a_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SCP_OFS_DIVCTL
      |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:4] == 3'h0)
      else $error("unused divider bits set");

   // Main scenarios reached
   c_wake: cover property ($fell(core_run_o) && !core_reset_o);
   c_tick: cover property (timer_tick_o);
   c_divwr: cover property (wb_ack_o && wb_we_i && wb_adr_i == `SCP_OFS_DIVCTL);
endmodule

`default_nettype wire

// file: scp_clock_ctrl_tb.sv
// Self-checking bench for the clock control block.
// Assumes the external clock model and checker compile first.
`timescale 1ns/10ps
`default_nettype none

module scp_clock_ctrl_tb;
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wake_i, ext_run;
   logic [3:0]  wb_adr_i, wb_sel_i, clock_source_fuses_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0]  startup_delay_fuses_i;
   logic [7:0]  factory_trim_i;
   logic        clock_output_fuse_i, divide_by_eight_fuse_i, gpio_out_i, gpio_oe_n_i;
   logic        main_osc_input_pin_i, timer_osc_input_pin_i, clock_output_pin_o;
   logic        clock_output_pin_oe_n_o, clk_io_en_o, clk_adc_en_o, clk_cpu_en_o;
   logic        clk_flash_en_o, core_reset_o, core_run_o, timer_osc_enable_o;
   logic        timer_tick_o, trim_range_bit_o;
   logic [6:0]  rc_trim_tune_o;
   int          fails, checks_done, cyc_cnt, g, n;

   // Short start-up delays keep the run brief
   scp_clock_ctrl #(.DLY_4MS_CYC(20), .DLY_65MS_CYC(40)) dut (.*);

   // Board clock source
   scp_ext_clk_src u_src (.run_i(ext_run), .main_pin_o(main_osc_input_pin_i),
      .timer_pin_o(timer_osc_input_pin_i));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One classic bus cycle; read data lands in rd
   task automatic wb(input logic [3:0] a, input logic w = 1'b0, input logic [7:0] d = 8'h0,
                     input logic [3:0] s = 4'h1);
      int k;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= s;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) fails++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Unlock then new select, back to back with nothing between
   task automatic change(input logic [3:0] c);
      wb(4'h4, 1'b1, 8'h80);
      wb(4'h4, 1'b1, {4'h0, c});
   endtask

   // Cycles between 3rd and 4th enable pulse or pin rise
   task automatic gap(input bit pin);
      int k, m;
      logic p, e;
      k = 0;
      m = 0;
      g = 0;
      p = clock_output_pin_o;
      while (k < 4 && m < 3000) begin
         @(posedge clk_i);
         m++;
         g++;
         e = pin ? (clock_output_pin_o & ~p) : clk_io_en_o;
         p = clock_output_pin_o;
         if (e === 1'b1) k++;
         if (e === 1'b1 && k == 3) g = 0;
      end
   endtask

   task automatic wait_run(input int lim);
      n = 0;
      while (core_run_o !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic s_boot();
      wait_run(300);
      chk(32'(core_run_o), 32'h1);
      wb(4'h0);
      chk(rd, 32'h5a);
      chk(32'({trim_range_bit_o, rc_trim_tune_o}), 32'h5a);
      wb(4'h4);
      chk(rd, 32'h03);
      wb(4'h2);
      chk(rd, 32'h0);
   endtask

   // No flash writes run here, so both trim ranges are safe
   task automatic s_trim();
      for (int i = 0; i < 2; i++) begin
         wb(4'h0, 1'b1, i ? 8'h7f : 8'h80);
         wb(4'h0);
         chk(32'({trim_range_bit_o, rc_trim_tune_o}), i ? 32'h7f : 32'h80);
      end
      wb(4'h0, 1'b1, 8'h11, 4'he);
      wb(4'h0);
      chk(rd, 32'h7f);
   endtask

   // Codes 0 to 9, reserved 9 included, from a fuse-set start
   task automatic s_codes();
      for (int c = 0; c < 10; c++) begin
         change(4'(c));
         wb(4'h4);
         chk(rd, 32'(c));
         gap(1'b0);
         chk(32'(g), c > 8 ? 32'd256 : 32'(1 << c));
         if (c == 2) begin
            gap(1'b1);
            chk(32'(g), 32'd8);
         end
      end
   endtask

   task automatic s_enable();
      change(4'h2);
      wb(4'h4, 1'b1, 8'h81);
      wb(4'h4, 1'b1, 8'h05);
      wb(4'h4);
      chk(rd, 32'h02);
      wb(4'h4, 1'b1, 8'h80);
      wb(4'h4);
      chk(rd, 32'h82);
      repeat (6) @(posedge clk_i);
      wb(4'h4, 1'b1, 8'h05);
      wb(4'h4);
      chk(rd, 32'h02);
      wb(4'h4, 1'b1, 8'h80);
      wb(4'h4, 1'b1, 8'h80);
      wb(4'h4, 1'b1, 8'h05);
      wb(4'h4);
      chk(rd, 32'h02);
      change(4'h3);
      wb(4'h4, 1'b1, 8'h80);
      wb(4'h4, 1'b1, 8'h73);
      wb(4'h4);
      chk(rd, 32'h03);
   endtask

   task automatic s_timer();
      chk(32'(timer_osc_enable_o), 32'h1);
      n = 0;
      while (timer_tick_o !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(timer_tick_o), 32'h1);
      wb(4'h8, 1'b1, 8'h01);
      wb(4'h8);
      chk(rd, 32'h1);
      chk(32'(timer_osc_enable_o), 32'h0);
   endtask

   task automatic s_wake();
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      n = 0;
      repeat (20) begin
         @(posedge clk_i);
         if (core_run_o === 1'b0) n++;
      end
      chk(32'(n >= 6 && n <= 8), 32'h1);
   endtask

   // External clock, fuses cleared except the short start-up delay, board clock held still at first
   task automatic s_external();
      @(posedge clk_i);
      rst_i <= 1'b1;
      clock_source_fuses_i <= 4'h0;
      clock_output_fuse_i <= 1'b0;
      divide_by_eight_fuse_i <= 1'b0;
      startup_delay_fuses_i <= 2'h1;
      gpio_out_i <= 1'b1;
      gpio_oe_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (clk_io_en_o === 1'b1) n++;
      end
      chk(32'(n), 32'h0);
      chk(32'(core_run_o), 32'h0);
      chk(32'({clock_output_pin_o, clock_output_pin_oe_n_o}), 32'h2);
      ext_run <= 1'b1;
      wait_run(3000);
      chk(32'(core_run_o), 32'h1);
      wb(4'h4);
      chk(rd, 32'h0);
      gap(1'b0);
      chk(32'(g > 1), 32'h1);
   endtask

   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Hang guard
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 60000) begin
         fails++;
         end_of_test();
      end
   end

   // Main sequence, internal RC with output and divide-by-eight fuses set
   initial begin
      {fails, checks_done, cyc_cnt} = '0;
      {wb_we_i, wb_cyc_i, wb_stb_i, wake_i, ext_run, gpio_out_i, gpio_oe_n_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      rst_i = 1'b1;
      clock_source_fuses_i = 4'h2;
      startup_delay_fuses_i = 2'h0;
      clock_output_fuse_i = 1'b1;
      divide_by_eight_fuse_i = 1'b1;
      factory_trim_i = 8'h5a;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      s_boot();
      s_trim();
      s_codes();
      s_enable();
      s_timer();
      s_wake();
      s_external();
      end_of_test();
   end
endmodule

bind scp_clock_ctrl scp_clock_ctrl_checker u_chk (.*);

`default_nettype wire
